// file: hdl/camera_gpio_line_control.sv
// apb register block, filters and drivers for four connector i/o lines
// What this block does
// - four configurable lines; a line index picks the one being set up
// - lines 1 and 2 have a direction setting, input or output; lines 0 and 3 stay inputs
// - supply enable exists only on lines supporting it; powers external parts
// - per-line inversion setting inverts the selected line's signal
// - per-line level readback gives one for high, zero for low
// - packed level word, bit n holds state of line n
// - per-line filters chosen by a type selector, width in microseconds
// - deglitch accepts a new level only after it persists the width
// - debounce passes first edge then blocks changes for the width
// - deglitch output feeds the debounce filter
// - output source picks loopback, user bit, counter, logic, exposure, wait
// - user output index picks a bit, level setting drives it
// - packed user output word reads and writes all bits at once
// - read-only circuit type per line: tri-state, opto or open-drain
// - open-drain pulls low for zero and releases for one
// - line 2 is bidirectional, its supply switched only by firmware
// - source selection acts only while the line is an output
`timescale 1ns/10ps
module camera_gpio_line_control #(
    parameter int unsigned FILTER_W = gpio_line_pkg::FILT_W
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // connector lines
    input  wire logic [3:0]  line_in,
    output logic      [3:0]  line_out,
    output logic      [3:0]  line_oe,
    output logic             line_supply_enable,
    // internal signals offered as line sources
    input  wire logic        counter_active,
    input  wire logic [1:0]  logic_block_out,
    input  wire logic        exposure_active,
    input  wire logic        frame_trigger_wait
);
    localparam int unsigned N = gpio_line_pkg::NUM_LINES;

    logic [1:0]          line_index_select_q;
    logic [N-1:0]        dir_out_q;
    logic [N-1:0]        line_invert_q;
    logic                supply_q;
    gpio_line_pkg::src_e output_drive_source_q [N];
    gpio_line_pkg::filt_e input_filter_type_select_q [N];
    logic [FILTER_W-1:0] glitch_us_q [N];
    logic [FILTER_W-1:0] bounce_us_q [N];
    logic [1:0]          soft_output_index_q;
    logic [3:0]          soft_output_word_q;
    logic [6:0]          tick_cnt_q;
    logic                us_tick;
    logic [N-1:0]        deglitch_q;
    logic [N-1:0]        debounce_q;
    logic [N-1:0]        in_state;
    logic [N-1:0]        drive_val;
    logic [N-1:0]        all_lines_level_word;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;
    logic [N-1:0]        line_out_q;
    logic [N-1:0]        line_oe_q;
    logic                supply_out_q;
    logic                acc_start;
    logic                acc_done;
    logic                wr_done;
    logic [1:0]          sel;

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign line_out           = line_out_q;
    assign line_oe            = line_oe_q;
    assign line_supply_enable = supply_out_q;

    assign acc_start = psel && penable && !pready_q;
    assign acc_done  = psel && penable && pready_q;
    assign wr_done   = acc_done && pwrite;
    assign sel       = line_index_select_q;

    // one wait state: pready rises in the cycle after the access phase starts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready_q <= 1'b0;
        else
            pready_q <= acc_start;
    end

    // microsecond tick shared by every filter; resolution is one microsecond
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_q <= 7'h00;
        else if (us_tick)
            tick_cnt_q <= 7'h00;
        else
            tick_cnt_q <= tick_cnt_q + 7'h01;
    end
    assign us_tick = (tick_cnt_q == gpio_line_pkg::TICK_LAST);

    // software writes to line setup, taken at the completing edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_index_select_q <= 2'h0;
            dir_out_q           <= '0;
            line_invert_q       <= '0;
            supply_q            <= 1'b0;
            soft_output_index_q <= 2'h0;
            soft_output_word_q  <= gpio_line_pkg::RST_SOFT_WORD;
            for (int i = 0; i < N; i++)
            begin
                output_drive_source_q[i]      <= gpio_line_pkg::SRC_LINE0;
                input_filter_type_select_q[i] <= gpio_line_pkg::FILT_DEGLITCH;
                glitch_us_q[i] <= gpio_line_pkg::RST_FILTER_US;
                bounce_us_q[i] <= gpio_line_pkg::RST_FILTER_US;
            end
        end
        else if (wr_done)
        begin
            unique case (paddr)
                gpio_line_pkg::OFF_LINE_INDEX:
                    line_index_select_q <= pwdata[1:0];
                gpio_line_pkg::OFF_LINE_CTRL:
                begin
                    if (sel == 2'(gpio_line_pkg::LINE_OPTO_OUT) ||
                        sel == 2'(gpio_line_pkg::LINE_GPIO))
                        dir_out_q[sel] <= pwdata[gpio_line_pkg::CTRL_DIR_BIT];
                    line_invert_q[sel] <= pwdata[gpio_line_pkg::CTRL_INV_BIT];
                    // supply switched by firmware, line 2 only
                    if (sel == 2'(gpio_line_pkg::LINE_GPIO))
                        supply_q <= pwdata[gpio_line_pkg::CTRL_SUP_BIT];
                    output_drive_source_q[sel] <= gpio_line_pkg::src_e'(
                        pwdata[gpio_line_pkg::CTRL_SRC_LSB +: 4]);
                end
                gpio_line_pkg::OFF_FILTER_SEL:
                    input_filter_type_select_q[sel] <=
                        gpio_line_pkg::filt_e'(pwdata[0]);
                gpio_line_pkg::OFF_FILTER_US:
                begin
                    if (input_filter_type_select_q[sel] ==
                        gpio_line_pkg::FILT_DEGLITCH)
                        glitch_us_q[sel] <= pwdata[FILTER_W-1:0];
                    else
                        bounce_us_q[sel] <= pwdata[FILTER_W-1:0];
                end
                gpio_line_pkg::OFF_SOFT_INDEX:
                    soft_output_index_q <= pwdata[1:0];
                gpio_line_pkg::OFF_SOFT_LEVEL:
                    soft_output_word_q[soft_output_index_q] <= pwdata[0];
                // all user bits in one write
                gpio_line_pkg::OFF_SOFT_WORD:
                    soft_output_word_q <= pwdata[3:0];
                default:
                    soft_output_word_q <= soft_output_word_q;
            endcase
        end
    end

    // every check below runs on pclk and sleeps through reset
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // per-line input filters and output source muxes
    for (genvar n = 0; n < N; n++)
    begin : g_line
        logic [FILTER_W-1:0] glitch_cnt_q;
        logic [FILTER_W-1:0] lock_cnt_q;

        // deglitch waits out the programmed width before accepting
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                deglitch_q[n] <= 1'b0;
                glitch_cnt_q  <= '0;
            end
            else if (line_in[n] == deglitch_q[n])
                glitch_cnt_q <= '0;
            else if (glitch_cnt_q >= glitch_us_q[n])
            begin
                deglitch_q[n] <= line_in[n];
                glitch_cnt_q  <= '0;
            end
            else if (us_tick)
                glitch_cnt_q <= glitch_cnt_q + 1'b1;
        end

        // debounce looks at the deglitched level only
        // first edge passes, then a lockout of the debounce width
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                debounce_q[n] <= 1'b0;
                lock_cnt_q    <= '0;
            end
            else if (lock_cnt_q != '0)
            begin
                if (us_tick)
                    lock_cnt_q <= lock_cnt_q - 1'b1;
            end
            else if (deglitch_q[n] != debounce_q[n])
            begin
                debounce_q[n] <= deglitch_q[n];
                lock_cnt_q    <= bounce_us_q[n];
            end
        end

        // source mux; illegal codes drive low
        always_comb
        begin
            case (output_drive_source_q[n])
                gpio_line_pkg::SRC_LINE0:    drive_val[n] = in_state[0];
                gpio_line_pkg::SRC_LINE1:    drive_val[n] = in_state[1];
                gpio_line_pkg::SRC_LINE2:    drive_val[n] = in_state[2];
                gpio_line_pkg::SRC_LINE3:    drive_val[n] = in_state[3];
                gpio_line_pkg::SRC_USER0:    drive_val[n] = soft_output_word_q[0];
                gpio_line_pkg::SRC_USER1:    drive_val[n] = soft_output_word_q[1];
                gpio_line_pkg::SRC_USER2:    drive_val[n] = soft_output_word_q[2];
                gpio_line_pkg::SRC_USER3:    drive_val[n] = soft_output_word_q[3];
                gpio_line_pkg::SRC_COUNTER:  drive_val[n] = counter_active;
                gpio_line_pkg::SRC_LOGIC0:   drive_val[n] = logic_block_out[0];
                gpio_line_pkg::SRC_LOGIC1:   drive_val[n] = logic_block_out[1];
                gpio_line_pkg::SRC_EXPOSURE: drive_val[n] = exposure_active;
                gpio_line_pkg::SRC_TRIG_WAIT:
                    drive_val[n] = frame_trigger_wait;
                default:                     drive_val[n] = 1'b0;
            endcase
        end

        // inversion on both the input and the output side
        assign in_state[n] = debounce_q[n] ^ line_invert_q[n];
        // readback shows the driven level on outputs
        assign all_lines_level_word[n] = dir_out_q[n] ?
            (drive_val[n] ^ line_invert_q[n]) : in_state[n];

        // nothing drives the pin while it is an input
        assert property (!dir_out_q[n] |-> ##1 !line_oe_q[n])
            else $error("line driven while set as input");
        // a level shorter than the width never passes
        assert property ((line_in[n] != deglitch_q[n]) && !us_tick &&
                         (glitch_cnt_q < glitch_us_q[n]) |=> $stable(deglitch_q[n]))
            else $error("deglitch passed a short level");
        // an idle debounce passes the edge in one cycle
        assert property ((lock_cnt_q == '0) &&
                         (deglitch_q[n] != debounce_q[n])
                         |=> debounce_q[n] == $past(deglitch_q[n]))
            else $error("debounce held the first edge");
    end

    // pin drivers: line 1 opto output, line 2 open drain, others never drive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_out_q   <= '0;
            line_oe_q    <= '0;
            supply_out_q <= 1'b0;
        end
        else
        begin
            line_out_q   <= '0;
            line_oe_q    <= '0;
            // supply rail only on the line that carries it
            supply_out_q <= supply_q;
            // opto output follows its source only in output mode
            line_out_q[gpio_line_pkg::LINE_OPTO_OUT] <=
                all_lines_level_word[gpio_line_pkg::LINE_OPTO_OUT];
            line_oe_q[gpio_line_pkg::LINE_OPTO_OUT] <=
                dir_out_q[gpio_line_pkg::LINE_OPTO_OUT];
            // open drain pulls low for zero, releases for one
            line_oe_q[gpio_line_pkg::LINE_GPIO] <=
                dir_out_q[gpio_line_pkg::LINE_GPIO] &&
                !all_lines_level_word[gpio_line_pkg::LINE_GPIO];
        end
    end

    // read data and error are loaded as pready rises; unmapped reads error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (acc_start)
        begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            unique case (paddr)
                gpio_line_pkg::OFF_LINE_INDEX:
                    prdata_q[1:0] <= line_index_select_q;
                gpio_line_pkg::OFF_LINE_CTRL:
                begin
                    prdata_q[gpio_line_pkg::CTRL_DIR_BIT] <= dir_out_q[sel];
                    prdata_q[gpio_line_pkg::CTRL_INV_BIT] <= line_invert_q[sel];
                    prdata_q[gpio_line_pkg::CTRL_SUP_BIT] <= supply_q &&
                        (sel == 2'(gpio_line_pkg::LINE_GPIO));
                    prdata_q[gpio_line_pkg::CTRL_SRC_LSB +: 4] <=
                        output_drive_source_q[sel];
                end
                gpio_line_pkg::OFF_FILTER_SEL:
                    prdata_q[0] <= input_filter_type_select_q[sel];
                gpio_line_pkg::OFF_FILTER_US:
                    prdata_q[FILTER_W-1:0] <=
                        (input_filter_type_select_q[sel] ==
                         gpio_line_pkg::FILT_DEGLITCH) ?
                        glitch_us_q[sel] : bounce_us_q[sel];
                gpio_line_pkg::OFF_LINE_LEVEL:
                    prdata_q[0] <= all_lines_level_word[sel];
                // every line level in one word
                gpio_line_pkg::OFF_ALL_LEVELS:
                    prdata_q[N-1:0] <= all_lines_level_word;
                gpio_line_pkg::OFF_SOFT_INDEX:
                    prdata_q[1:0] <= soft_output_index_q;
                gpio_line_pkg::OFF_SOFT_LEVEL:
                    prdata_q[0] <= soft_output_word_q[soft_output_index_q];
                // all user bits in one read
                gpio_line_pkg::OFF_SOFT_WORD:
                    prdata_q[3:0] <= soft_output_word_q;
                gpio_line_pkg::OFF_LINE_TYPE:
                    prdata_q[1:0] <= (sel == 2'(gpio_line_pkg::LINE_GPIO)) ?
                        gpio_line_pkg::TYPE_OPEN_DRAIN :
                        (sel == 2'(gpio_line_pkg::LINE_PLAIN_IN)) ?
                        gpio_line_pkg::TYPE_TRI_STATE :
                        gpio_line_pkg::TYPE_OPTO;
                default:
                    pslverr_q <= 1'b1;
            endcase
        end
    end

    sequence acc_begin_s;
        psel && penable && !pready;
    endsequence
    sequence acc_end_s;
        pready ##1 !pready;
    endsequence

    apb_answer_a: assert property (acc_begin_s |=> acc_end_s)
        else $error("apb answer not one wait state");
    all_levels_a: assert property (acc_start && !pwrite &&
        paddr == gpio_line_pkg::OFF_ALL_LEVELS
        |=> prdata[3:0] == $past(all_lines_level_word))
        else $error("level word read wrong");
    soft_level_a: assert property (wr_done &&
        paddr == gpio_line_pkg::OFF_SOFT_LEVEL
        |=> soft_output_word_q[$past(soft_output_index_q)] == $past(pwdata[0]))
        else $error("user bit not written");
    soft_word_a: assert property (wr_done &&
        paddr == gpio_line_pkg::OFF_SOFT_WORD
        |=> soft_output_word_q == $past(pwdata[3:0]))
        else $error("user word not written");
    fixed_dir_a: assert property (!dir_out_q[0] && !dir_out_q[3])
        else $error("input-only line became output");
    open_drain_a: assert property (!line_out[2])
        else $error("open drain drove high");
    supply_follow_a: assert property (supply_q |=> line_supply_enable)
        else $error("supply not switched on");
    line_type_a: assert property (acc_start && !pwrite &&
        paddr == gpio_line_pkg::OFF_LINE_TYPE && sel == 2'h2
        |=> prdata[1:0] == gpio_line_pkg::TYPE_OPEN_DRAIN)
        else $error("line type wrong");
endmodule

// file: hdl/gpio_line_pkg.sv
// constants and types shared by the i/o line controller
package gpio_line_pkg;
    localparam int unsigned NUM_LINES = 4;
    localparam int unsigned FILT_W    = 16;
    // register byte offsets
    localparam logic [7:0] OFF_LINE_INDEX  = 8'h00;
    localparam logic [7:0] OFF_LINE_CTRL   = 8'h04;
    localparam logic [7:0] OFF_FILTER_SEL  = 8'h08;
    localparam logic [7:0] OFF_FILTER_US   = 8'h0C;
    localparam logic [7:0] OFF_LINE_LEVEL  = 8'h10;
    localparam logic [7:0] OFF_ALL_LEVELS  = 8'h14;
    localparam logic [7:0] OFF_SOFT_INDEX  = 8'h18;
    localparam logic [7:0] OFF_SOFT_LEVEL  = 8'h1C;
    localparam logic [7:0] OFF_SOFT_WORD   = 8'h20;
    localparam logic [7:0] OFF_LINE_TYPE   = 8'h24;
    // line control field positions
    localparam int unsigned CTRL_DIR_BIT   = 0;
    localparam int unsigned CTRL_INV_BIT   = 1;
    localparam int unsigned CTRL_SUP_BIT   = 2;
    localparam int unsigned CTRL_SRC_LSB   = 4;
    // lines with fixed roles
    localparam int unsigned LINE_OPTO_IN   = 0;
    localparam int unsigned LINE_OPTO_OUT  = 1;
    localparam int unsigned LINE_GPIO      = 2;
    localparam int unsigned LINE_PLAIN_IN  = 3;
    // reset values
    localparam logic [3:0] RST_SOFT_WORD   = 4'h0;
    localparam logic [FILT_W-1:0] RST_FILTER_US = 16'h0000;
    // microsecond tick from the 125 MHz clock
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned TICK_US        = 1;
    localparam int unsigned CYC_PER_US     = (TICK_US * 1000) / CLK_PERIOD_NS;
    localparam logic [6:0] TICK_LAST       = 7'(CYC_PER_US - 1);

    typedef enum logic [3:0] {
        SRC_LINE0, SRC_LINE1, SRC_LINE2, SRC_LINE3,
        SRC_USER0, SRC_USER1, SRC_USER2, SRC_USER3,
        SRC_COUNTER, SRC_LOGIC0, SRC_LOGIC1,
        SRC_EXPOSURE, SRC_TRIG_WAIT
    } src_e;

    typedef enum logic [1:0] {
        TYPE_TRI_STATE, TYPE_OPTO, TYPE_OPEN_DRAIN
    } circuit_e;

    typedef enum logic {
        FILT_DEGLITCH, FILT_DEBOUNCE
    } filt_e;
endpackage

// file: testbench/line_partner.sv
// external wiring model for the four connector lines
`timescale 1ns/10ps
module line_partner (
    // design side
    input  wire logic [3:0] line_out,
    input  wire logic [3:0] line_oe,
    // far side levels, a high on line 2 means released
    input  wire logic [3:0] ext_level,
    // pin levels seen by the design
    output logic      [3:0] line_in
);
    // pull-up release
    // the pull-up only loses to an active low, never to a released pin
    assign line_in[2] = (line_oe[2] && !line_out[2]) ? 1'b0 : ext_level[2];
    // opto output echo
    // line 1 reads back its own drive while it is an output
    assign line_in[1] = line_oe[1] ? line_out[1] : ext_level[1];
    // plain inputs follow the far side
    assign line_in[0] = ext_level[0];
    assign line_in[3] = ext_level[3];
endmodule

// file: testbench/tb.sv
// self-checking bench for the connector line controller
`timescale 1ns/10ps
module tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  line_in;
    logic [3:0]  line_out;
    logic [3:0]  line_oe;
    logic        line_supply_enable;
    logic [4:0]  src_q;  // trig, exposure, logic1, logic0, counter
    logic [3:0]  ext_q;
    logic [31:0] rd_q;
    logic        err_q;
    int          n_fail;
    int          tests_run;
    int          cyc;

    // clock and timeout; a hang still reaches the verdict
    always #4 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    camera_gpio_line_control dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_in(line_in),
        .line_out(line_out), .line_oe(line_oe),
        .line_supply_enable(line_supply_enable),
        .counter_active(src_q[0]), .logic_block_out(src_q[2:1]),
        .exposure_active(src_q[3]), .frame_trigger_wait(src_q[4]));
    line_partner far_end (
        .line_out(line_out), .line_oe(line_oe), .ext_level(ext_q),
        .line_in(line_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready high ends this wait; without it only the bench timeout does
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd_q, exp);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic t_defaults;
        rd(gpio_line_pkg::OFF_LINE_CTRL, 32'h0);
        rd(gpio_line_pkg::OFF_SOFT_WORD, 32'h0);
        chk({line_oe, line_out, 3'h0, line_supply_enable}, 32'h0);
    endtask

    task automatic t_types;
        for (int l = 0; l < 4; l++)
        begin
            wr(gpio_line_pkg::OFF_LINE_INDEX, 32'(l));
            rd(gpio_line_pkg::OFF_LINE_TYPE, l == 2 ? 32'h2 : 32'(l < 2));
        end
    endtask

    task automatic t_levels;
        ext_q <= 4'h5;
        wt(6);
        rd(gpio_line_pkg::OFF_ALL_LEVELS, 32'h5);
        wr(gpio_line_pkg::OFF_LINE_INDEX, 32'h0);
        rd(gpio_line_pkg::OFF_LINE_LEVEL, 32'h1);
        wr(gpio_line_pkg::OFF_LINE_CTRL, 32'h2);
        wt(4);
        rd(gpio_line_pkg::OFF_LINE_LEVEL, 32'h0);
        wr(gpio_line_pkg::OFF_LINE_CTRL, 32'h1);
        rd(gpio_line_pkg::OFF_LINE_CTRL, 32'h0);
        wr(gpio_line_pkg::OFF_LINE_INDEX, 32'h1);
        wr(gpio_line_pkg::OFF_LINE_CTRL, 32'h4);
        chk(32'(line_supply_enable), 32'h0);
    endtask

    // line 1 sources: codes alternate between high and low on purpose
    task automatic t_sources;
        wr(gpio_line_pkg::OFF_SOFT_WORD, 32'h5);
        wr(gpio_line_pkg::OFF_LINE_CTRL, 32'h40);
        wt(3);
        chk(32'(line_oe[1]), 32'h0);
        for (int p = 0; p < 2; p++)
        begin
            src_q <= p ? 5'h0A : 5'h15;
            for (int c = p * 8; c < 13; c++)
            begin
                if (c == 1)
                    continue;
                wr(gpio_line_pkg::OFF_LINE_CTRL, 32'(c * 16 + 1));
                wt(3);
                chk({line_oe[1], line_out[1]}, {1'b1, 1'(c % 2 == p)});
            end
        end
        wr(gpio_line_pkg::OFF_SOFT_INDEX, 32'h1);
        wr(gpio_line_pkg::OFF_SOFT_LEVEL, 32'h1);
        rd(gpio_line_pkg::OFF_SOFT_WORD, 32'h7);
    endtask

    task automatic t_drain;
        wr(gpio_line_pkg::OFF_LINE_INDEX, 32'h2);
        wr(gpio_line_pkg::OFF_LINE_CTRL, 32'h45);
        wt(3);
        chk({line_oe[2], line_supply_enable}, 32'h1);
        wr(gpio_line_pkg::OFF_SOFT_WORD, 32'h0);
        wt(5);
        chk({line_oe[2], line_out[2]}, 32'h2);
        rd(gpio_line_pkg::OFF_LINE_LEVEL, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk({rd_q[30:0], err_q}, 32'h1);
    endtask

    task automatic t_filters;
        wr(gpio_line_pkg::OFF_LINE_INDEX, 32'h3);
        wr(gpio_line_pkg::OFF_FILTER_SEL, 32'h0);
        wr(gpio_line_pkg::OFF_FILTER_US, 32'h3);
        ext_q[3] <= 1'b1;
        wt(100);
        ext_q[3] <= 1'b0;
        wt(400);
        rd(gpio_line_pkg::OFF_LINE_LEVEL, 32'h0);
        ext_q[3] <= 1'b1;
        wt(150);
        rd(gpio_line_pkg::OFF_LINE_LEVEL, 32'h0);
        wt(500);
        rd(gpio_line_pkg::OFF_LINE_LEVEL, 32'h1);
        wr(gpio_line_pkg::OFF_FILTER_US, 32'h0);
        wr(gpio_line_pkg::OFF_FILTER_SEL, 32'h1);
        wr(gpio_line_pkg::OFF_FILTER_US, 32'h4);
        ext_q[3] <= 1'b0;
        wt(5);
        rd(gpio_line_pkg::OFF_LINE_LEVEL, 32'h0);
        ext_q[3] <= 1'b1;
        wt(5);
        rd(gpio_line_pkg::OFF_LINE_LEVEL, 32'h0);
        wt(600);
        rd(gpio_line_pkg::OFF_LINE_LEVEL, 32'h1);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // reset for eight cycles, then the scenarios in order
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_q, src_q, n_fail, tests_run, cyc} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults();
        t_types();
        t_levels();
        t_sources();
        t_drain();
        t_filters();
        wrap_up();
    end
endmodule
